// File: pkg/ccp_unit_map.vh
`ifndef CCP_UNIT_MAP_VH
`define CCP_UNIT_MAP_VH

// Register indices; the byte address on the bus is four times the index.
`define IDX_PORT_DATA 10'h006
`define IDX_FLAG 10'h00C
`define IDX_CC_LOW 10'h015
`define IDX_CC_HIGH 10'h016
`define IDX_CONTROL 10'h017
`define IDX_DIRECTION 10'h086
`define IDX_ENABLE 10'h08C

// Field positions.
`define CTRL_DUTY_HI 5
`define CTRL_DUTY_LO 4
`define CTRL_MODE_HI 3
`define CTRL_MODE_LO 0
`define CTRL_GROUP_HI 3
`define CTRL_GROUP_LO 2
`define FLAG_UNIT_BIT 2
`define FLAG_OVF_BIT 0
`define ENABLE_UNIT_BIT 2
`define PIN_BIT_LOC0 3'h0
`define PIN_BIT_LOC1 3'h3

// Reset values.
`define CONTROL_RESET 8'h00
`define DIRECTION_RESET 8'hFF
`define PORT_DATA_RESET 8'h00
`define CC_RESET 8'h00

// Mode codes of the four-bit mode field.
`define MODE_OFF 4'h0
`define MODE_CAP_FALL 4'h4
`define MODE_CAP_RISE 4'h5
`define MODE_CAP_4TH 4'h6
`define MODE_CAP_16TH 4'h7
`define MODE_CMP_SET 4'h8
`define MODE_CMP_CLR 4'h9
`define MODE_CMP_IRQ 4'hA
`define MODE_CMP_TRIG 4'hB
`define GROUP_CAPTURE 2'h1
`define GROUP_COMPARE 2'h2
`define GROUP_PWM 2'h3

// Edge selection taken from the two low mode bits in capture.
`define CAP_SEL_FALL 2'h0
`define CAP_SEL_RISE 2'h1
`define CAP_SEL_4TH 2'h2
`define CAP_SEL_16TH 2'h3
`define PRESCALE_4TH_LAST 2'h3
`define PRESCALE_16TH_LAST 4'hF

// Bus responses.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: rtl/capture_edge_prescaler.v
`timescale 1ns/100ps
`include "ccp_unit_map.vh"

module capture_edge_prescaler (
  input wire clk_sys,
  input wire reset_n,
  input wire pinIn,
  input wire captureActive,
  input wire [1:0] edgeSelect,
  output wire captureEvent
);

  reg pinMeta_r;
  reg pinSync_r;
  reg pinPrev_r;
  reg [3:0] edgeCount_r;
  reg [3:0] edgeCount_nxt;
  reg eventHit;
  wire riseSeen;
  wire fallSeen;

  assign riseSeen = pinSync_r & ~pinPrev_r;
  assign fallSeen = ~pinSync_r & pinPrev_r;

  // The meta stage feeds only the sync stage, so one pin edge yields one detected edge.
  always @(posedge clk_sys or negedge reset_n) begin // see [RULE25]
    if (!reset_n) begin
      pinMeta_r <= 1'b0;
      pinSync_r <= 1'b0;
      pinPrev_r <= 1'b0;
      edgeCount_r <= 4'h0;
    end else begin
      pinMeta_r <= pinIn;
      pinSync_r <= pinMeta_r;
      pinPrev_r <= pinSync_r;
      edgeCount_r <= edgeCount_nxt;
    end
  end

  // A switch between prescale settings keeps the count, so the first capture may come early.
  always @* begin
    edgeCount_nxt = edgeCount_r;
    if (!captureActive) begin
      edgeCount_nxt = 4'h0; // see [RULE9]
    end else if (riseSeen) begin
      edgeCount_nxt = edgeCount_r + 4'h1; // see [RULE10]
    end
  end

  always @* begin
    eventHit = 1'b0;
    case (edgeSelect) // see [RULE2]
      `CAP_SEL_FALL: eventHit = fallSeen;
      `CAP_SEL_RISE: eventHit = riseSeen;
      `CAP_SEL_4TH: eventHit = riseSeen & (edgeCount_r[1:0] == `PRESCALE_4TH_LAST);
      `CAP_SEL_16TH: eventHit = riseSeen & (edgeCount_r == `PRESCALE_16TH_LAST);
      default: eventHit = 1'b0;
    endcase
  end

  assign captureEvent = captureActive & eventHit;

endmodule

// File: rtl/capture_compare_pwm_unit.v
// Contract
// [RULE1] Capture copies the full 16-bit first timer count into the capture word.
// [RULE2] Capture event: each falling, each rising, every 4th or 16th rising edge.
// [RULE3] Mode field: 0000 off, 01xx capture, 10xx compare variants, 11xx PWM.
// [RULE4] Every capture sets the unit flag at bit 2; software clears it.
// [RULE5] A new capture overwrites an unread older value without any overrun mark.
// [RULE6] With the pin driven as output, a port write changing it may capture.
// [RULE7] Software runs the first timer synchronously for capture or compare.
// [RULE8] Software masks the unit interrupt while changing mode, then clears the flag.
// [RULE9] Prescale counter clears whenever the unit is off or not capturing.
// [RULE10] Switching prescale settings directly keeps the counter and may raise the flag.
// [RULE11] Software writes zero to control, then the new mode, to change prescale.
// [RULE12] Compare matches word with first timer; drives pin high, low or unchanged.
// [RULE13] A compare match sets the flag in the same cycle the pin acts.
// [RULE14] Writing zero to control forces the compare output latch low.
// [RULE15] Interrupt-only compare leaves the pin alone and only raises the flag.
// [RULE16] Special trigger match resets the first timer and starts a conversion.
// [RULE17] The special-trigger timer reset never sets the overflow flag at bit 0.
// [RULE18] PWM mode produces up to 10-bit duty PWM on the output-enabled pin.
// [RULE19] Writing zero to control forces the PWM output latch low.
// [RULE20] PWM period is (period register + 1) times four ticks times prescale.
// [RULE21] At period end: clear second timer, set pin unless duty zero, latch duty.
// [RULE22] The second timer postscaler plays no part in the PWM period.
// [RULE23] Duty is low byte as eight upper bits and control bits 5:4 below.
// [RULE24] Pin clears when latched duty equals timer plus two phase bits.
// [RULE25] The pin is synchronised before edge detection; each edge counts once.
// [RULE26] In PWM mode the high byte is read-only; writes to it are dropped.
`timescale 1ns/100ps
`include "ccp_unit_map.vh"

module capture_compare_pwm_unit (
  input wire clk_sys,
  input wire reset_n,
  input wire [11:0] awaddr,
  input wire awvalid,
  output wire awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  output wire [1:0] bresp,
  output wire bvalid,
  input wire bready,
  input wire [11:0] araddr,
  input wire arvalid,
  output wire arready,
  output wire [31:0] rdata,
  output wire [1:0] rresp,
  output wire rvalid,
  input wire rready,
  input wire [15:0] firstTimerCount,
  input wire firstTimerOverflow,
  input wire [7:0] secondTimerCount,
  input wire secondTimerTick,
  input wire [7:0] pwmPeriodRegister,
  input wire [1:0] quarterPhase,
  input wire converterEnable,
  input wire pinLocationSelect,
  input wire pinIn,
  output wire pinOut,
  output wire pinOutEnable_n,
  output wire firstTimerReset,
  output wire conversionStart,
  output wire secondTimerClear,
  output wire unitInterruptRequest
);

  reg [7:0] ccLow_r;
  reg [7:0] ccLow_nxt;
  reg [7:0] ccHigh_r;
  reg [7:0] ccHigh_nxt;
  reg [7:0] control_r;
  reg [7:0] direction_r;
  reg [7:0] portData_r;
  reg [1:0] dutyLsbLatch_r;
  reg unitFlag_r;
  reg overflowFlag_r;
  reg unitEnable_r;
  reg outLatch_r;
  reg outLatch_nxt;
  reg matchPrev_r;
  reg firstTimerReset_r;
  reg conversionStart_r;
  reg awHeld_r;
  reg wHeld_r;
  reg [9:0] awIndex_r;
  reg [7:0] wByte_r;
  reg wLane_r;
  reg bvalid_r;
  reg [1:0] bresp_r;
  reg rvalid_r;
  reg [1:0] rresp_r;
  reg [31:0] rdata_r;
  reg [7:0] readByte;
  reg readMapped;

  wire [3:0] mode;
  wire [1:0] modeGroup;
  wire captureMode;
  wire compareMode;
  wire pwmMode;
  wire captureEvent;
  wire compareMatch;
  wire matchEvent;
  wire specialTrigger;
  wire periodEnd;
  wire dutyMatch;
  wire [9:0] dutyWord;
  wire [9:0] shadowDuty;
  wire [2:0] pinBit;
  wire awTake;
  wire wTake;
  wire writeFire;
  wire [9:0] wrIndex;
  wire [7:0] wrByte;
  wire wrLane;
  wire wrMapped;
  wire wrEn;
  wire wrControl;
  wire wrFlag;
  wire arTake;

  function isMapped;
    input [9:0] index;
    begin
      isMapped = (index == `IDX_PORT_DATA) || (index == `IDX_FLAG) ||
                 (index == `IDX_CC_LOW) || (index == `IDX_CC_HIGH) ||
                 (index == `IDX_CONTROL) || (index == `IDX_DIRECTION) ||
                 (index == `IDX_ENABLE);
    end
  endfunction

  assign mode = control_r[`CTRL_MODE_HI:`CTRL_MODE_LO];
  assign modeGroup = control_r[`CTRL_GROUP_HI:`CTRL_GROUP_LO];
  assign captureMode = (modeGroup == `GROUP_CAPTURE); // see [RULE3]
  assign compareMode = (modeGroup == `GROUP_COMPARE);
  assign pwmMode = (modeGroup == `GROUP_PWM);

  // Write address and data are taken independently and held until both are here.
  assign awready = ~awHeld_r & ~bvalid_r;
  assign wready = ~wHeld_r & ~bvalid_r;
  assign awTake = awvalid & awready;
  assign wTake = wvalid & wready;
  assign writeFire = (awHeld_r | awTake) & (wHeld_r | wTake);
  assign wrIndex = awHeld_r ? awIndex_r : awaddr[11:2];
  assign wrByte = wHeld_r ? wByte_r : wdata[7:0];
  // Only byte lane 0 carries a register; a write without it is answered but changes nothing.
  assign wrLane = wHeld_r ? wLane_r : wstrb[0];
  assign wrMapped = isMapped(wrIndex);
  assign wrEn = writeFire & wrLane & wrMapped;
  assign wrControl = wrEn & (wrIndex == `IDX_CONTROL);
  assign wrFlag = wrEn & (wrIndex == `IDX_FLAG);
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;

  assign arready = ~rvalid_r;
  assign arTake = arvalid & arready;
  assign rvalid = rvalid_r;
  assign rresp = rresp_r;
  assign rdata = rdata_r;

  // The pin is sampled whatever its direction, so a port write that moves a driven pin
  // comes back through pinIn and can capture like an outside edge.
  capture_edge_prescaler edgeUnit (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .pinIn(pinIn), // see [RULE6]
    .captureActive(captureMode),
    .edgeSelect(mode[1:0]),
    .captureEvent(captureEvent)
  );

  // A match is an event only on its first cycle, since a prescaled timer sits on a value.
  assign compareMatch = compareMode & (firstTimerCount == {ccHigh_r, ccLow_r}); // see [RULE12]
  assign matchEvent = compareMatch & ~matchPrev_r;
  assign specialTrigger = matchEvent & (mode == `MODE_CMP_TRIG);

  // The tick is the prescaled increment of the second timer, never its postscaled output,
  // so the period is (period register + 1) ticks of four phases each.
  assign periodEnd = pwmMode & secondTimerTick & (secondTimerCount == pwmPeriodRegister); // see [RULE22]
  assign secondTimerClear = periodEnd; // see [RULE20]
  assign dutyWord = {ccLow_r, control_r[`CTRL_DUTY_HI:`CTRL_DUTY_LO]}; // see [RULE23]
  assign shadowDuty = {ccHigh_r, dutyLsbLatch_r};
  assign dutyMatch = pwmMode & ({secondTimerCount, quarterPhase} == shadowDuty); // see [RULE24]

  assign pinBit = pinLocationSelect ? `PIN_BIT_LOC1 : `PIN_BIT_LOC0;
  // The direction bit is the enable itself, so a 1 in it leaves the pin to the outside.
  assign pinOutEnable_n = direction_r[pinBit]; // see [RULE18]
  assign pinOut = (compareMode | pwmMode) ? outLatch_r : portData_r[pinBit];
  assign firstTimerReset = firstTimerReset_r;
  assign conversionStart = conversionStart_r;
  assign unitInterruptRequest = unitFlag_r & unitEnable_r;

  always @* begin
    ccLow_nxt = ccLow_r;
    if (captureEvent) begin
      ccLow_nxt = firstTimerCount[7:0]; // see [RULE1] [RULE5]
    end else if (wrEn && (wrIndex == `IDX_CC_LOW)) begin
      ccLow_nxt = wrByte;
    end
  end

  always @* begin
    ccHigh_nxt = ccHigh_r;
    if (captureEvent) begin
      ccHigh_nxt = firstTimerCount[15:8]; // see [RULE1] [RULE5]
    end else if (periodEnd) begin
      ccHigh_nxt = ccLow_r; // see [RULE21]
    end else if (wrEn && (wrIndex == `IDX_CC_HIGH) && !pwmMode) begin
      ccHigh_nxt = wrByte; // see [RULE26]
    end
  end

  // Period start wins over a duty match in the same cycle; a duty beyond the period never
  // matches, so the pin then stays high for the whole period.
  always @* begin
    outLatch_nxt = outLatch_r;
    if ((wrControl && (wrByte == 8'h00)) || (mode == `MODE_OFF)) begin
      outLatch_nxt = 1'b0; // see [RULE14] [RULE19]
    end else if (compareMode) begin
      if (matchEvent && (mode == `MODE_CMP_SET)) begin
        outLatch_nxt = 1'b1; // see [RULE12]
      end else if (matchEvent && (mode == `MODE_CMP_CLR)) begin
        outLatch_nxt = 1'b0; // see [RULE12]
      end
    end else if (pwmMode) begin
      if (periodEnd) begin
        outLatch_nxt = (dutyWord != 10'h000); // see [RULE21]
      end else if (dutyMatch) begin
        outLatch_nxt = 1'b0; // see [RULE24]
      end
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ccLow_r <= `CC_RESET;
      ccHigh_r <= `CC_RESET;
      control_r <= `CONTROL_RESET;
      direction_r <= `DIRECTION_RESET;
      portData_r <= `PORT_DATA_RESET;
      dutyLsbLatch_r <= 2'h0;
      unitFlag_r <= 1'b0;
      overflowFlag_r <= 1'b0;
      unitEnable_r <= 1'b0;
      outLatch_r <= 1'b0;
      matchPrev_r <= 1'b0;
      firstTimerReset_r <= 1'b0;
      conversionStart_r <= 1'b0;
    end else begin
      ccLow_r <= ccLow_nxt;
      ccHigh_r <= ccHigh_nxt;
      outLatch_r <= outLatch_nxt;
      matchPrev_r <= compareMatch;
      if (wrControl) begin
        control_r <= {2'h0, wrByte[5:0]};
      end
      if (wrEn && (wrIndex == `IDX_DIRECTION)) begin
        direction_r <= wrByte;
      end
      if (wrEn && (wrIndex == `IDX_PORT_DATA)) begin
        portData_r <= wrByte;
      end
      if (wrEn && (wrIndex == `IDX_ENABLE)) begin
        unitEnable_r <= wrByte[`ENABLE_UNIT_BIT];
      end
      if (periodEnd) begin
        dutyLsbLatch_r <= control_r[`CTRL_DUTY_HI:`CTRL_DUTY_LO]; // see [RULE21]
      end
      // A set arriving with a software clear wins, so no event is lost.
      unitFlag_r <= captureEvent | matchEvent |
                    (unitFlag_r & ~(wrFlag & wrByte[`FLAG_UNIT_BIT])); // see [RULE4] [RULE13] [RULE15]
      // Only the outside timer's own overflow sets this bit; the trigger's reset does not.
      overflowFlag_r <= firstTimerOverflow |
                        (overflowFlag_r & ~(wrFlag & wrByte[`FLAG_OVF_BIT])); // see [RULE17]
      firstTimerReset_r <= specialTrigger; // see [RULE16]
      conversionStart_r <= specialTrigger & converterEnable; // see [RULE16]
    end
  end

  // Reads have no side effect, so polling the capture word never loses or marks a value.
  always @* begin
    readByte = 8'h00;
    readMapped = 1'b1;
    case (araddr[11:2])
      `IDX_PORT_DATA: readByte = portData_r;
      `IDX_FLAG: begin
        readByte[`FLAG_UNIT_BIT] = unitFlag_r;
        readByte[`FLAG_OVF_BIT] = overflowFlag_r;
      end
      `IDX_CC_LOW: readByte = ccLow_r;
      `IDX_CC_HIGH: readByte = ccHigh_r;
      `IDX_CONTROL: readByte = {2'h0, control_r[5:0]};
      `IDX_DIRECTION: readByte = direction_r;
      `IDX_ENABLE: readByte[`ENABLE_UNIT_BIT] = unitEnable_r;
      default: readMapped = 1'b0;
    endcase
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awIndex_r <= 10'h000;
      wByte_r <= 8'h00;
      wLane_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= `RESP_OKAY;
      rdata_r <= 32'h00000000;
    end else begin
      if (writeFire) begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wrMapped ? `RESP_OKAY : `RESP_SLVERR;
      end else begin
        if (awTake) begin
          awHeld_r <= 1'b1;
          awIndex_r <= awaddr[11:2];
        end
        if (wTake) begin
          wHeld_r <= 1'b1;
          wByte_r <= wdata[7:0];
          wLane_r <= wstrb[0];
        end
        if (bvalid_r && bready) begin
          bvalid_r <= 1'b0;
        end
      end
      if (arTake) begin
        rvalid_r <= 1'b1;
        rdata_r <= {24'h000000, readByte};
        rresp_r <= readMapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid_r && rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

endmodule

// File: verification/ccp_unit_checker.sv
`timescale 1ns/100ps
module ccp_unit_checker (
  input logic clk_sys,
  input logic reset_n,
  input logic awvalid,
  input logic awready,
  input logic wvalid,
  input logic wready,
  input logic bvalid,
  input logic bready,
  input logic arvalid,
  input logic arready,
  input logic rvalid,
  input logic rready,
  input logic [31:0] rdata,
  input logic firstTimerReset,
  input logic conversionStart,
  input logic converterEnable,
  input logic secondTimerClear,
  input logic secondTimerTick,
  input logic [7:0] secondTimerCount,
  input logic [7:0] pwmPeriodRegister
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_trig_single: assert property (firstTimerReset |=> !firstTimerReset)
    else $error("trigger pulse too long");
  a_conv_with_trig: assert property (conversionStart |-> firstTimerReset)
    else $error("conversion start without trigger");
  a_conv_gated: assert property (
    firstTimerReset && converterEnable && $past(converterEnable) |-> conversionStart)
    else $error("conversion start missing");
  a_clear_at_end: assert property (
    secondTimerClear |-> secondTimerTick && secondTimerCount == pwmPeriodRegister)
    else $error("timer clear off period end");
  a_write_answer: assert property (awvalid && awready && wvalid && wready |=> bvalid && !awready)
    else $error("write response missing");
  a_b_ends: assert property (bvalid && bready |=> !bvalid)
    else $error("write response held too long");
  a_read_answer: assert property (arvalid && arready |=> rvalid && rdata[31:8] == 24'h000000)
    else $error("read answer late or wide");
  a_r_ends: assert property (rvalid && rready |=> !rvalid)
    else $error("read answer held too long");
endmodule

bind capture_compare_pwm_unit ccp_unit_checker ccp_unit_checker_i (
  .clk_sys(clk_sys), .reset_n(reset_n), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
  .firstTimerReset(firstTimerReset), .conversionStart(conversionStart),
  .converterEnable(converterEnable), .secondTimerClear(secondTimerClear),
  .secondTimerTick(secondTimerTick), .secondTimerCount(secondTimerCount),
  .pwmPeriodRegister(pwmPeriodRegister));

// File: verification/pin_partner.sv
`timescale 1ns/100ps
module pin_partner (
  input logic pinOut,
  input logic pinOutEnable_n,
  input logic extLevel,
  output logic pinLevel
);
  // A driven pin reads back its own level, so a port write can start a capture.
  assign pinLevel = !pinOutEnable_n ? pinOut : extLevel;
endmodule

// File: verification/tb.sv
`timescale 1ns/100ps
`include "ccp_unit_map.vh"
module tb;
  localparam [1:0] OK = `RESP_OKAY;
  localparam [1:0] ER = `RESP_SLVERR;
  localparam [9:0] ctl = `IDX_CONTROL;
  localparam [9:0] ccLo = `IDX_CC_LOW;
  localparam [9:0] ccHi = `IDX_CC_HIGH;
  localparam [9:0] flg = `IDX_FLAG;
  logic clk_sys = 1'h0;
  logic reset_n = 1'h0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [15:0] firstTimerCount = 16'h0000;
  logic secondTimerTick = 1'h0, converterEnable = 1'h0, extLevel = 1'h0;
  logic [7:0] secondTimerCount = 8'h00;
  logic [1:0] quarterPhase = 2'h0;
  wire awready, wready, bvalid, arready, rvalid, pinIn, pinOut, pinOutEnable_n;
  wire firstTimerReset, conversionStart, secondTimerClear, unitInterruptRequest;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  integer error_cnt = 0, samples_checked = 0, trigCnt = 0, convCnt = 0, i, k, h;
  logic [31:0] lf = 32'h200C;
  logic [15:0] x;
  logic [9:0] d;
  logic [3:0] cm [0:5] = '{4'h8, 4'hA, 4'hA, 4'h8, 4'h9, 4'hB};
  logic [5:0] cz = 6'h04;
  logic [5:0] cp = 6'h0B;
  logic [3:0] strobe = 4'hF;
  logic ovfPulse = 1'h0, pinSel = 1'h0;
  logic [7:0] period = 8'h03;

  capture_compare_pwm_unit capture_compare_pwm_unit_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(strobe), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .firstTimerCount(firstTimerCount), .firstTimerOverflow(ovfPulse),
    .secondTimerCount(secondTimerCount), .secondTimerTick(secondTimerTick),
    .pwmPeriodRegister(period), .quarterPhase(quarterPhase),
    .converterEnable(converterEnable), .pinLocationSelect(pinSel), .pinIn(pinIn),
    .pinOut(pinOut), .pinOutEnable_n(pinOutEnable_n), .firstTimerReset(firstTimerReset),
    .conversionStart(conversionStart), .secondTimerClear(secondTimerClear),
    .unitInterruptRequest(unitInterruptRequest));
  pin_partner pin_partner_i (.pinOut(pinOut), .pinOutEnable_n(pinOutEnable_n),
    .extLevel(extLevel), .pinLevel(pinIn));

  initial forever #5 clk_sys = ~clk_sys;
  // Second timer with quarter phases wraps at the period, so a period is 4 * (period + 1).
  always @(posedge clk_sys) begin
    quarterPhase <= quarterPhase + 2'h1;
    secondTimerTick <= quarterPhase == 2'h2;
    if (secondTimerTick) begin
      secondTimerCount <= (secondTimerCount >= period) ? 8'h00 : secondTimerCount + 8'h01;
    end
    trigCnt <= trigCnt + firstTimerReset;
    convCnt <= convCnt + conversionStart;
  end

  function automatic [31:0] lfsr(input [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic integer edges(input integer m);
    edges = m < 2 ? 2 : (m == 2 ? 5 : 17);
  endfunction
  function automatic bit capAt(input integer m, input integer n);
    capAt = m < 2 || (m == 2 ? n % 4 == 0 : n % 16 == 0);
  endfunction
  // The clear is registered, so the pin stays high through the matching phase.
  // The window is 32 cycles, a whole number of periods for periods of 8 or 16 cycles.
  function automatic integer pwmHigh(input [9:0] v, input [7:0] p);
    integer n;
    n = 4 * (p + 1);
    pwmHigh = v == 10'h000 ? 0 : (v >= n - 1 ? 32 : (v + 1) * (32 / n));
  endfunction

  task complete_run;
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task giveUp;
    error_cnt = error_cnt + 1;
    $display("Error at %0t: wait ran out, got %h expected %h", $time, 1'h0, 1'h1);
    complete_run;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked = samples_checked + 1;
    if (g !== e) begin
      error_cnt = error_cnt + 1;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input [9:0] a, input [7:0] v, input [1:0] er);
    integer n;
    logic ha, hw, hb;
    logic [1:0] r;
    @(posedge clk_sys);
    awaddr <= {a, 2'h0};
    wdata <= {24'h0, v};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    hb = 1'h0;
    for (n = 0; n < 50 && !hb; n = n + 1) begin
      @(negedge clk_sys);
      ha = awready;
      hw = wready;
      hb = bvalid;
      r = bresp;
      @(posedge clk_sys);
      if (ha) awvalid <= 1'h0;
      if (hw) wvalid <= 1'h0;
      if (hb) bready <= 1'h0;
    end
    if (!hb) giveUp;
    chk(32'(r), 32'(er));
  endtask
  task rd(input [9:0] a, input [7:0] v, input [1:0] er);
    integer n;
    logic ha, hr;
    logic [31:0] q;
    logic [1:0] r;
    @(posedge clk_sys);
    araddr <= {a, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    hr = 1'h0;
    for (n = 0; n < 50 && !hr; n = n + 1) begin
      @(negedge clk_sys);
      ha = arready;
      hr = rvalid;
      q = rdata;
      r = rresp;
      @(posedge clk_sys);
      if (ha) arvalid <= 1'h0;
      if (hr) rready <= 1'h0;
    end
    if (!hr) giveUp;
    chk(q, {24'h0, v});
    chk(32'(r), 32'(er));
  endtask
  task pulse;
    @(posedge clk_sys);
    extLevel <= 1'h1;
    repeat (6) @(posedge clk_sys);
    extLevel <= 1'h0;
    repeat (6) @(posedge clk_sys);
  endtask

  initial begin
    repeat (90000) @(posedge clk_sys);
    giveUp;
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'h1;
    rd(ctl, `CONTROL_RESET, OK);
    rd(`IDX_DIRECTION, `DIRECTION_RESET, OK);
    rd(10'h3FF, 8'h00, ER);
    wr(10'h3FF, 8'h12, ER);
    for (i = 0; i < 4; i = i + 1) begin
      wr(ctl, 8'h00, OK);
      wr(ctl, 8'(4 + i), OK);
      wr(ccLo, 8'h00, OK);
      wr(ccHi, 8'h00, OK);
      wr(flg, 8'hFF, OK);
      x = 16'h0000;
      for (k = 1; k <= edges(i); k = k + 1) begin
        lf = lfsr(lf);
        firstTimerCount <= lf[15:0];
        if (capAt(i, k)) x = lf[15:0];
        pulse;
      end
      rd(ccLo, x[7:0], OK);
      rd(ccHi, x[15:8], OK);
      rd(flg, 8'h04, OK);
      wr(flg, 8'hFF, OK);
    end
    wr(ctl, 8'h00, OK);
    wr(ctl, 8'h01, OK);
    pulse;
    rd(flg, 8'h00, OK);
    wr(ctl, 8'h05, OK);
    wr(`IDX_DIRECTION, 8'hFE, OK);
    chk(32'(pinOutEnable_n), 32'h0);
    pinSel <= 1'h1;
    @(posedge clk_sys);
    chk(32'(pinOutEnable_n), 32'h1);
    pinSel <= 1'h0;
    lf = lfsr(lf);
    x = lf[15:0];
    firstTimerCount <= x;
    wr(`IDX_PORT_DATA, 8'h01, OK);
    repeat (6) @(posedge clk_sys);
    rd(ccLo, x[7:0], OK);
    strobe <= 4'h0;
    wr(ccLo, ~x[7:0], OK);
    strobe <= 4'hF;
    rd(ccLo, x[7:0], OK);
    wr(`IDX_PORT_DATA, 8'h00, OK);
    wr(flg, 8'hFF, OK);
    wr(`IDX_ENABLE, 8'h04, OK);
    converterEnable <= 1'h1;
    lf = lfsr(lf);
    x = lf[15:0];
    wr(ccLo, x[7:0], OK);
    wr(ccHi, x[15:8], OK);
    for (i = 0; i < 6; i = i + 1) begin
      firstTimerCount <= ~x;
      if (cz[i]) wr(ctl, 8'h00, OK);
      wr(ctl, {4'h0, cm[i]}, OK);
      firstTimerCount <= x;
      repeat (3) @(posedge clk_sys);
      chk(32'(pinOut), 32'(cp[i]));
      chk(32'(unitInterruptRequest), 32'h1);
      rd(flg, 8'h04, OK);
      wr(flg, 8'hFF, OK);
    end
    chk(trigCnt, 1);
    chk(convCnt, 1);
    ovfPulse <= 1'h1;
    @(posedge clk_sys);
    ovfPulse <= 1'h0;
    rd(flg, 8'h01, OK);
    wr(flg, 8'h01, OK);
    rd(flg, 8'h00, OK);
    wr(ctl, 8'h00, OK);
    for (i = 0; i < 5; i = i + 1) begin
      lf = lfsr(lf);
      d = i == 0 ? 10'h000 : (i == 1 ? 10'h006 : (i == 2 ? {6'h00, lf[3:0] | 4'h1} : 10'h3FF));
      if (i == 4) begin
        period <= 8'h01;
        d = 10'h005;
      end
      wr(ccLo, d[9:2], OK);
      wr(ctl, {2'h0, d[1:0], 4'hC}, OK);
      repeat (40) @(posedge clk_sys);
      h = 0;
      repeat (32) begin
        @(negedge clk_sys);
        h = h + pinOut;
      end
      chk(h, pwmHigh(d, period));
      wr(ccHi, 8'h55, OK);
      rd(ccHi, d[9:2], OK);
    end
    complete_run;
  end
endmodule
